// ==== verilog/uart_dp_pkg.sv ====
// Purpose : constants and types of the serial port transmit/receive data path
// Assumes : APB register map, one aligned 32-bit word per register
// Notes   : register offsets are byte addresses
//
// Behaviour
// R1 - software sets the ninth transmit bit before writing the low data byte
// R2 - buffer empty flag high while transmit buffer empty, low while it holds data
// R3 - buffer empty interrupt requested continuously while flag set and enabled
// R4 - writing the data register clears buffer empty until moved to shifter
// R5 - software writes zero to the buffer empty flag position
// R6 - transmit complete set when frame sent and transmit buffer empty
// R7 - transmit complete cleared by interrupt service or by writing one
// R8 - transmit complete interrupt requested when flag set and enabled
// R9 - parity bit inserted after last data bit, before first stop bit
// R10 - transmitter disable waits until shifter and buffer empty, then releases pin
// R11 - receive enable makes receiver own the receive pin
// R12 - synchronous mode uses external serial clock pin as bit clock
// R13 - reception starts on valid start bit, shifts bits to first stop bit
// R14 - receiver ignores any second stop bit
// R15 - on first stop bit the frame moves into the receive buffer
// R16 - unused high data bits of short characters read as zero
// R17 - ninth bit and frame, overrun, parity errors stored with each frame
// R18 - reading data advances the fifo; status and ninth bit read first
// R19 - two-entry buffer; overrun when full, shifter holding, new start seen
// R20 - receive complete reflects unread data; disabling receiver flushes buffer
// R21 - shifter loads buffer when idle or right after last stop bit
`default_nettype none

package uart_dp_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA = 8'h00;  // serial_data_reg
   localparam logic [7:0] ADDR_CSA  = 8'h04;  // ctrl_status_a
   localparam logic [7:0] ADDR_CSB  = 8'h08;  // ctrl_status_b
   localparam logic [7:0] ADDR_CSC  = 8'h0C;  // frame format
   localparam logic [7:0] ADDR_BAUD = 8'h10;  // clocks per bit

   // ctrl_status_a fields
   localparam int CSA_RXC  = 7;
   localparam int CSA_TXC  = 6;
   localparam int CSA_UDRE = 5;
   localparam int CSA_FE   = 4;
   localparam int CSA_DOR  = 3;
   localparam int CSA_PE   = 2;
   // ctrl_status_b fields
   localparam int CSB_TXCIE = 6;
   localparam int CSB_UDRIE = 5;
   localparam int CSB_RXEN  = 4;
   localparam int CSB_TRANSMIT_ENABLE  = 3;
   localparam int CSB_CSZ2  = 2;
   localparam int CSB_RX9   = 1;
   localparam int CSB_TX9   = 0;
   // frame format fields
   localparam int CSC_SYNC  = 6;
   localparam int CSC_PM1   = 5;
   localparam int CSC_PM0   = 4;
   localparam int CSC_STOP2 = 3;
   localparam int CSC_CSZ1  = 2;
   localparam int CSC_CSZ0  = 1;

   // reset values and the nine-bit size code
   localparam logic [7:0]  CSB_RST  = 8'h00;
   localparam logic [7:0]  CSC_RST  = 8'h06;  // eight data bits, no parity
   localparam logic [15:0] BAUD_RST = 16'h000A;
   localparam logic [2:0]  CSZ_NINE = 3'h7;

   // fifo entry: {pe, dor, fe, ninth, data[7:0]}
   localparam int ENT_W = 12;

   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
      TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
   } tx_state_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
      RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
   } rx_state_t;

   // number of data bits for a character size code
   function automatic logic [3:0] data_bits(input logic [2:0] csz);
      case (csz)
         3'h0:    data_bits = 4'h5;
         3'h1:    data_bits = 4'h6;
         3'h2:    data_bits = 4'h7;
         3'h7:    data_bits = 4'h9;
         default: data_bits = 4'h8;
      endcase
   endfunction

endpackage

`default_nettype wire

// ==== verilog/uart_tx_rx_datapath_flags.sv ====
// Purpose : transmit and receive data path with flags, reached over APB
// Assumes : pins synchronous to sys_clk_i; baud divider gives clocks per bit
// Notes   : synchronous mode shifts out on rising and samples on falling edge
//
// The address map and the APB slave port were left to the implementer.
`default_nettype none

module uart_tx_rx_datapath_flags
   import uart_dp_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // interrupt requests
   output logic             tx_buf_empty_irq_o,
   output logic             tx_complete_irq_o,
   input  wire logic        tx_complete_irq_ack_i,
   // line side
   output logic             serial_out_pin_o,
   output logic             serial_out_pin_oe_n_o,
   input  wire logic        serial_in_pin_i,
   output logic             serial_in_pin_owned_o,
   input  wire logic        sync_clock_pin_i
);

   // ----------------------------------------------------------------
   // registers and bus decode
   // ----------------------------------------------------------------
   logic [7:0]  csb_reg;
   logic [7:0]  csc_reg;
   logic [15:0] baud_reg;
   logic        txc_reg;
   logic        tbuf_full_reg;
   logic [8:0]  tbuf_reg;
   logic        pop_ok_reg;
   logic [ENT_W-1:0] fifo_mem [2];
   logic        wr_ptr_reg;
   logic        rd_ptr_reg;
   logic [1:0]  rx_count_reg;

   logic        setup, wr_acc, rd_acc, mapped;
   logic [2:0]  csz;
   logic [3:0]  nbits;
   logic [ENT_W-1:0] head;

   assign setup  = psel_i & ~penable_i;
   assign wr_acc = psel_i & penable_i & pwrite_i;
   assign rd_acc = psel_i & penable_i & ~pwrite_i;
   assign mapped = (paddr_i == ADDR_DATA) | (paddr_i == ADDR_CSA) | (paddr_i == ADDR_CSB) |
                   (paddr_i == ADDR_CSC) | (paddr_i == ADDR_BAUD);
   assign csz    = {csb_reg[CSB_CSZ2], csc_reg[CSC_CSZ1], csc_reg[CSC_CSZ0]};
   assign nbits  = data_bits(csz);
   assign head   = fifo_mem[rd_ptr_reg];

   // every access completes in one access cycle; unmapped answers with error
   assign pready_o  = psel_i & penable_i;
   assign pslverr_o = psel_i & penable_i & ~mapped;

   // control registers; the ninth receive bit and status bits are read only, except TXC, cleared by writing one
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         csb_reg  <= CSB_RST;
         csc_reg  <= CSC_RST;
         baud_reg <= BAUD_RST;
      end else if (wr_acc) begin
         if (paddr_i == ADDR_CSB) csb_reg <= {1'b0, pwdata_i[6:2], 1'b0, pwdata_i[0]};
         if (paddr_i == ADDR_CSC) csc_reg <= {1'b0, pwdata_i[6:1], 1'b0};
         if (paddr_i == ADDR_BAUD) baud_reg <= pwdata_i[15:0];
      end
   end

   // read data is fetched at setup so it stays stable through the access
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o   <= 32'h0000_0000;
         pop_ok_reg <= 1'b0;
      end else if (setup & ~pwrite_i) begin
         prdata_o   <= 32'h0000_0000;
         pop_ok_reg <= (paddr_i == ADDR_DATA) && (rx_count_reg != 2'h0);
         case (paddr_i)
            ADDR_DATA: if (rx_count_reg != 2'h0) prdata_o[7:0] <= head[7:0]; // [R16]
            ADDR_CSA:  prdata_o[7:0] <= {rx_count_reg != 2'h0, txc_reg, ~tbuf_full_reg,
                                         head[9] & (rx_count_reg != 2'h0),
                                         head[10] & (rx_count_reg != 2'h0),
                                         head[11] & (rx_count_reg != 2'h0), 2'h0}; // [R20]
            ADDR_CSB:  prdata_o[7:0] <= {csb_reg[7:2], head[8] & (rx_count_reg != 2'h0),
                                         csb_reg[0]}; // [R17]
            ADDR_CSC:  prdata_o[7:0] <= csc_reg;
            ADDR_BAUD: prdata_o[15:0] <= baud_reg;
            default:   prdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // bit timing
   // ----------------------------------------------------------------
   logic        sync_mode;
   logic        xck_q_reg;
   logic        xck_rise, xck_fall;
   logic [15:0] tx_cnt_reg;
   logic        tx_tick, tx_load;

   assign sync_mode = csc_reg[CSC_SYNC];
   assign xck_rise  = sync_clock_pin_i & ~xck_q_reg;
   assign xck_fall  = ~sync_clock_pin_i & xck_q_reg;

   // external clock edge detect; the pin is taken as already synchronous
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) xck_q_reg <= 1'b0;
      else       xck_q_reg <= sync_clock_pin_i;
   end

   // transmit bit counter, restarted at load so the start bit lasts a whole bit
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i)                   tx_cnt_reg <= 16'h0000;
      else if (tx_cnt_reg == 16'h0000 || tx_load) tx_cnt_reg <= baud_reg - 16'h0001;
      else                         tx_cnt_reg <= tx_cnt_reg - 16'h0001;
   end
   assign tx_tick = sync_mode ? xck_rise : (tx_cnt_reg == 16'h0000); // [R12]

   // ----------------------------------------------------------------
   // transmitter
   // ----------------------------------------------------------------
   tx_state_t   tx_state_reg;
   logic [8:0]  tx_sr_reg;
   logic [3:0]  tx_bit_reg;
   logic        tx_par_reg;
   logic        tx_owned_reg;
   logic        tx_last_stop;
   logic [8:0]  tmask;

   assign tmask        = 9'h1FF >> (4'h9 - nbits);
   assign tx_last_stop = tx_tick && (tx_state_reg == TX_STOP) &&
                         (tx_bit_reg == {3'h0, csc_reg[CSC_STOP2]});
   // load from buffer when idle or straight after the last stop bit
   assign tx_load = tbuf_full_reg && tx_owned_reg &&
                    (tx_state_reg == TX_IDLE || tx_last_stop); // [R21]

   // transmit buffer; holds until moved into the shifter
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tbuf_full_reg <= 1'b0;
         tbuf_reg      <= 9'h000;
      end else if (wr_acc && paddr_i == ADDR_DATA) begin
         tbuf_full_reg <= 1'b1; // [R4]
         tbuf_reg      <= {csb_reg[CSB_TX9], pwdata_i[7:0]}; // [R1]
      end else if (tx_load) begin
         tbuf_full_reg <= 1'b0; // [R2]
      end
   end

   // disable takes effect only once shifter and buffer are both empty
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i)                   tx_owned_reg <= 1'b0;
      else if (csb_reg[CSB_TRANSMIT_ENABLE])  tx_owned_reg <= 1'b1;
      else if (tx_state_reg == TX_IDLE && !tbuf_full_reg) tx_owned_reg <= 1'b0; // [R10]
   end

   // frame sequencer: start, data lsb first, optional parity, stop bits
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state_reg     <= TX_IDLE;
         tx_sr_reg        <= 9'h000;
         tx_bit_reg       <= 4'h0;
         tx_par_reg       <= 1'b0;
         serial_out_pin_o <= 1'b1;
      end else if (tx_load) begin
         tx_state_reg     <= TX_START;
         tx_sr_reg        <= tbuf_reg & tmask;
         tx_par_reg       <= (^(tbuf_reg & tmask)) ^ csc_reg[CSC_PM0];
         tx_bit_reg       <= 4'h0;
         serial_out_pin_o <= 1'b0; // start bit waits a full tick
      end else if (tx_tick) begin
         case (tx_state_reg)
            TX_START: begin
               tx_state_reg     <= TX_DATA;
               serial_out_pin_o <= tx_sr_reg[0];
               tx_sr_reg        <= tx_sr_reg >> 1;
               tx_bit_reg       <= 4'h1;
            end
            TX_DATA: begin
               if (tx_bit_reg == nbits) begin
                  tx_bit_reg <= 4'h0;
                  if (csc_reg[CSC_PM1]) begin
                     tx_state_reg     <= TX_PAR;
                     serial_out_pin_o <= tx_par_reg; // [R9]
                  end else begin
                     tx_state_reg     <= TX_STOP;
                     serial_out_pin_o <= 1'b1;
                  end
               end else begin
                  serial_out_pin_o <= tx_sr_reg[0];
                  tx_sr_reg        <= tx_sr_reg >> 1;
                  tx_bit_reg       <= tx_bit_reg + 4'h1;
               end
            end
            TX_PAR: begin
               tx_state_reg     <= TX_STOP;
               serial_out_pin_o <= 1'b1;
            end
            TX_STOP: begin
               if (tx_last_stop) tx_state_reg <= TX_IDLE;
               else tx_bit_reg <= tx_bit_reg + 4'h1;
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // transmit complete: hardware set wins over either clear
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) txc_reg <= 1'b0;
      else if (tx_last_stop && !tbuf_full_reg) txc_reg <= 1'b1; // [R6]
      else if (tx_complete_irq_ack_i || (wr_acc && paddr_i == ADDR_CSA && pwdata_i[CSA_TXC]))
         txc_reg <= 1'b0; // [R7]
   end

   // buffer empty flag ignores writes to its position [R5]
   assign tx_buf_empty_irq_o    = csb_reg[CSB_UDRIE] & ~tbuf_full_reg; // [R3]
   assign tx_complete_irq_o     = csb_reg[CSB_TXCIE] & txc_reg; // [R8]
   assign serial_out_pin_oe_n_o = ~tx_owned_reg; // [R10]

   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   rx_state_t   rx_state_reg;
   logic [15:0] rx_cnt_reg;
   logic [8:0]  rx_sr_reg;
   logic [3:0]  rx_bit_reg;
   logic        rx_par_reg;
   logic        pend_valid_reg;
   logic [ENT_W-1:0] pend_reg;
   logic        dor_reg;
   logic        rx_en, rx_tick, pin, start_seen, push, pop;
   logic [8:0]  rx_data;

   assign rx_en   = csb_reg[CSB_RXEN];
   assign pin     = rx_en ? serial_in_pin_i : 1'b1; // [R11]
   assign serial_in_pin_owned_o = rx_en;
   assign rx_tick = sync_mode ? xck_fall : (rx_cnt_reg == 16'h0000); // [R12]
   assign rx_data = rx_sr_reg >> (4'h9 - nbits); // [R16]
   // a start bit counts once it is confirmed
   assign start_seen = sync_mode ? (rx_state_reg == RX_IDLE && xck_fall && !pin)
                                 : (rx_state_reg == RX_START && rx_tick && !pin);
   assign push = pend_valid_reg && (rx_count_reg != 2'h2);
   assign pop  = rd_acc && pop_ok_reg; // [R18]

   // bit sequencer; async mode samples mid bit after a half bit start check
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_reg <= RX_IDLE;
         rx_cnt_reg   <= 16'h0000;
         rx_sr_reg    <= 9'h000;
         rx_bit_reg   <= 4'h0;
         rx_par_reg   <= 1'b0;
      end else if (!rx_en) begin
         rx_state_reg <= RX_IDLE; // disabling aborts a reception at once
      end else begin
         rx_cnt_reg <= (rx_cnt_reg == 16'h0000) ? baud_reg - 16'h0001 : rx_cnt_reg - 16'h0001;
         case (rx_state_reg)
            RX_IDLE: begin
               rx_bit_reg <= 4'h0;
               if (sync_mode) begin
                  if (start_seen) rx_state_reg <= RX_DATA; // [R13]
               end else if (!pin) begin
                  rx_state_reg <= RX_START;
                  rx_cnt_reg   <= {1'b0, baud_reg[15:1]};
               end
            end
            RX_START: if (rx_tick) rx_state_reg <= pin ? RX_IDLE : RX_DATA; // [R13]
            RX_DATA: if (rx_tick) begin
               rx_sr_reg  <= {pin, rx_sr_reg[8:1]};
               rx_bit_reg <= rx_bit_reg + 4'h1;
               if (rx_bit_reg + 4'h1 == nbits)
                  rx_state_reg <= csc_reg[CSC_PM1] ? RX_PAR : RX_STOP;
            end
            RX_PAR: if (rx_tick) begin
               rx_par_reg   <= pin;
               rx_state_reg <= RX_STOP;
            end
            // only the first stop bit is sampled; a second one reads as idle
            RX_STOP: if (rx_tick) rx_state_reg <= RX_IDLE; // [R14]
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // completed frame waits in the shifter stage until the fifo has room
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_valid_reg <= 1'b0;
         pend_reg       <= '0;
      end else if (!rx_en) begin
         pend_valid_reg <= 1'b0;
      end else if (rx_state_reg == RX_STOP && rx_tick) begin
         pend_valid_reg <= 1'b1; // [R15]
         pend_reg <= {csc_reg[CSC_PM1] & ((^rx_data) ^ csc_reg[CSC_PM0] ^ rx_par_reg),
                      1'b0, ~pin, rx_data}; // [R17]
      end else if (push) begin
         pend_valid_reg <= 1'b0;
      end
   end

   // overrun: remembered until a frame is moved into the fifo
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) dor_reg <= 1'b0;
      else if (!rx_en) dor_reg <= 1'b0;
      else if (start_seen && pend_valid_reg && rx_count_reg == 2'h2) dor_reg <= 1'b1; // [R19]
      else if (push) dor_reg <= 1'b0;
   end

   // two-entry receive fifo
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_reg   <= 1'b0;
         rd_ptr_reg   <= 1'b0;
         rx_count_reg <= 2'h0;
      end else if (!rx_en) begin
         wr_ptr_reg   <= 1'b0; // [R20]
         rd_ptr_reg   <= 1'b0;
         rx_count_reg <= 2'h0;
      end else begin
         if (push) wr_ptr_reg <= ~wr_ptr_reg;
         if (pop)  rd_ptr_reg <= ~rd_ptr_reg; // [R18]
         rx_count_reg <= rx_count_reg + {1'b0, push} - {1'b0, pop}; // [R19]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) fifo_mem[wr_ptr_reg] <= {pend_reg[11], dor_reg, pend_reg[9:0]}; // [R17]
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_udre_clear;
      @(posedge sys_clk_i) disable iff (rst_i)
      wr_acc && paddr_i == ADDR_DATA |=> !tx_buf_empty_irq_o && tbuf_full_reg;
   endproperty
   a_udre_clear: assert property (p_udre_clear) else $error("data write left buffer empty"); // [R4]

   property p_udre_irq;
      @(posedge sys_clk_i) disable iff (rst_i)
      csb_reg[CSB_UDRIE] && !tbuf_full_reg |-> tx_buf_empty_irq_o;
   endproperty
   a_udre_irq: assert property (p_udre_irq) else $error("buffer empty request missing"); // [R3]

   property p_txc_set;
      @(posedge sys_clk_i) disable iff (rst_i)
      tx_last_stop && !tbuf_full_reg |=> txc_reg ##1 (txc_reg || $past(tx_complete_irq_ack_i) || $past(wr_acc));
   endproperty
   a_txc_set: assert property (p_txc_set) else $error("transmit complete not set"); // [R6]

   property p_txc_ack;
      @(posedge sys_clk_i) disable iff (rst_i)
      tx_complete_irq_ack_i && !tx_last_stop |=> !txc_reg;
   endproperty
   a_txc_ack: assert property (p_txc_ack) else $error("transmit complete not cleared"); // [R7]

   property p_txc_irq;
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(txc_reg) && csb_reg[CSB_TXCIE] |-> tx_complete_irq_o;
   endproperty
   a_txc_irq: assert property (p_txc_irq) else $error("transmit complete request missing"); // [R8]

   property p_parity_bit;
      @(posedge sys_clk_i) disable iff (rst_i)
      tx_state_reg == TX_PAR |-> serial_out_pin_o == tx_par_reg && csc_reg[CSC_PM1];
   endproperty
   a_parity_bit: assert property (p_parity_bit) else $error("wrong parity on line"); // [R9]

   property p_tx_release;
      @(posedge sys_clk_i) disable iff (rst_i)
      !serial_out_pin_oe_n_o && (tx_state_reg != TX_IDLE || tbuf_full_reg) |=> !serial_out_pin_oe_n_o;
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("pin released mid frame"); // [R10]

   property p_rx_flush;
      @(posedge sys_clk_i) disable iff (rst_i)
      !rx_en |=> rx_count_reg == 2'h0 && !pend_valid_reg;
   endproperty
   a_rx_flush: assert property (p_rx_flush) else $error("receive buffer not flushed"); // [R20]

   property p_rx_store;
      @(posedge sys_clk_i) disable iff (rst_i)
      rx_en && rx_state_reg == RX_STOP && rx_tick |=> pend_valid_reg ##1 (rx_count_reg != 2'h0 || !rx_en);
   endproperty
   a_rx_store: assert property (p_rx_store) else $error("frame not stored"); // [R15]

   c_back_to_back: cover property (@(posedge sys_clk_i) disable iff (rst_i) tx_last_stop && tx_load);
   c_rx_full:      cover property (@(posedge sys_clk_i) disable iff (rst_i) rx_count_reg == 2'h2);
   c_overrun:      cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(dor_reg));

endmodule

`default_nettype wire

// ==== tb/serial_peer.sv ====
// Purpose : remote serial device on the line side of the port
// Assumes : asynchronous framing, BIT_CLKS system clocks per bit
// Notes   : our line idles high between frames, as a released line must
`default_nettype none

module serial_peer #(
   parameter int BIT_CLKS = 4
) (
   input  wire logic clk_i,
   input  wire logic line_in_i,
   output logic      line_out_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial line_out_o = 1'b1;

   // ----------------------------------------------------------------
   // frame out: start, n bits lsb first, one stop, then idle high
   // ----------------------------------------------------------------
   task automatic send(input logic [10:0] bits, input int n);
      for (int i = -1; i <= n; i++) begin
         line_out_o <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : bits[i];
         repeat (BIT_CLKS) @(posedge clk_i);
      end
   endtask

   // ----------------------------------------------------------------
   // frame in: mid-bit sampling, index n holds the first stop bit
   // ----------------------------------------------------------------
   task automatic grab(input int n, output logic [10:0] bits);
      bits = '0;
      @(negedge line_in_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i <= n; i++) begin
         repeat (BIT_CLKS) @(posedge clk_i);
         bits[i] = line_in_i;
      end
   endtask
endmodule

`default_nettype wire

// ==== tb/tb_uart_tx_rx_datapath_flags.sv ====
// Purpose : self-checking bench of the serial data path and its flags
// Assumes : four clocks per bit so frames stay short
// Notes   : receive rows first, then fifo, flush, synchronous receive and transmit cases
`default_nettype none

module tb_uart_tx_rx_datapath_flags;
   import uart_dp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int BITC = 4;
   typedef struct packed {logic [1:0] csz; logic [7:0] sent; logic [7:0] got;} row_t;
   row_t        rows [4] = '{'{2'h0, 8'hFF, 8'h1F}, '{2'h1, 8'hEA, 8'h2A}, '{2'h2, 8'hD5, 8'h55},
                             '{2'h3, 8'hA5, 8'hA5}};
   logic [10:0] f9 [4]   = '{11'h13C, 11'h0C3, 11'h111, 11'h05A};
   logic [9:0]  exp9 [3] = '{10'h13C, 10'h0C3, 10'h25A};  // third frame is lost
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ack = 1'b0, xck = 1'b0;
   logic        sin, sout, oe_n, own, i_be, i_tc, prdy, perr, serr;
   logic [7:0]  paddr = '0;
   logic [31:0] pwd = '0, prd, q;
   logic [10:0] bits;
   int          err_total = 0, checks_done = 0, cyc = 0;

   always #25 clk = ~clk;

   uart_tx_rx_datapath_flags DUT (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
      .pslverr_o(perr), .tx_buf_empty_irq_o(i_be), .tx_complete_irq_o(i_tc),
      .tx_complete_irq_ack_i(ack), .serial_out_pin_o(sout), .serial_out_pin_oe_n_o(oe_n),
      .serial_in_pin_i(sin), .serial_in_pin_owned_o(own), .sync_clock_pin_i(xck));
   serial_peer #(.BIT_CLKS(BITC)) PEER (.clk_i(clk), .line_in_i(sout), .line_out_o(sin));

   // ----------------------------------------------------------------
   // checking, closing and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d, errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // request held until pready is seen high, idle cycle after it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      q = prd;
      serr = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, {24'h0, e});
   endtask

   // hang guard, generous against roughly 700 cycles of work
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({sout, oe_n, own, i_be, i_tc}, 32'h18);
      rdc(ADDR_CSA, 8'h20);
      rdc(8'h14, 8'h00);
      chk(serr, 1'b1);
      wr(ADDR_BAUD, BITC);
      wr(ADDR_CSB, 8'h10);
      chk(own, 1'b1);
      foreach (rows[i]) begin
         wr(ADDR_CSC, {5'h0, rows[i].csz, 1'b0});
         PEER.send({3'h0, rows[i].sent}, 5 + rows[i].csz);
         repeat (6) @(posedge clk);
         rdc(ADDR_CSA, 8'hA0);
         rdc(ADDR_DATA, rows[i].got);
         rdc(ADDR_CSA, 8'h20);
      end
      // nine-bit frames back to back: two stored, one pending, one overruns
      wr(ADDR_CSB, 8'h14);
      wr(ADDR_CSC, 8'h06);
      foreach (f9[i]) PEER.send(f9[i], 9);
      repeat (6) @(posedge clk);
      foreach (exp9[i]) begin
         rdc(ADDR_CSA, 8'hA0 | {4'h0, exp9[i][9], 3'h0});
         rdc(ADDR_CSB, {6'h05, exp9[i][8], 1'b0});
         rdc(ADDR_DATA, exp9[i][7:0]);
      end
      PEER.send(11'h0AA, 9);
      repeat (6) @(posedge clk);
      wr(ADDR_CSB, 8'h00);
      rdc(ADDR_CSA, 8'h20);
      chk(own, 1'b0);
      // synchronous reception: line changes on xck rising, sampled on falling; xck idles low
      wr(ADDR_CSB, 8'h10);
      wr(ADDR_CSC, 8'h46);
      fork
         PEER.send(11'h0C5, 8);
         repeat (10) begin
            xck <= 1'b1;
            repeat (2) @(posedge clk);
            xck <= 1'b0;
            repeat (2) @(posedge clk);
         end
      join
      repeat (6) @(posedge clk);
      rdc(ADDR_DATA, 8'hC5);
      // transmit, nine bits with even parity, ninth bit set before the data write
      wr(ADDR_CSC, 8'h26);
      wr(ADDR_CSB, 8'h0D);
      fork
         PEER.grab(10, bits);
         wr(ADDR_DATA, 8'h97);
      join
      chk(bits, 11'h597);
      repeat (4) @(posedge clk);
      rdc(ADDR_CSA, 8'h60);
      wr(ADDR_CSB, 8'h48);
      chk(i_tc, 1'b1);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(posedge clk);
      chk(i_tc, 1'b0);
      wr(ADDR_CSB, 8'h20);
      chk(i_be, 1'b1);
      wr(ADDR_DATA, 8'h55);
      chk(i_be, 1'b0);
      rdc(ADDR_CSA, 8'h00);
      fork
         PEER.grab(9, bits);
         begin
            wr(ADDR_CSB, 8'h28);
            repeat (2) @(posedge clk);
            chk(i_be, 1'b1);
            wr(ADDR_CSB, 8'h00);
            chk(oe_n, 1'b0);
         end
      join
      chk(bits, 11'h255);
      repeat (4) @(posedge clk);
      chk(oe_n, 1'b1);
      rdc(ADDR_CSA, 8'h60);
      wr(ADDR_CSA, 8'h40);
      rdc(ADDR_CSA, 8'h20);
      end_sim();
   end
endmodule

`default_nettype wire
